/* File: rtl/line_interface_reset_pll_control.v */
// reset, float and pll control for the line interface core
// assumes external pins arrive asynchronous; fabric signals are on core_clk_i
//
// Operation
// - power-up resets all four blocks, floats io
// - async resets held at least 8 ns
// - async assert, synchronised release accepted
// - global or routed fabric reset resets both
// - configuration resets all blocks, io active
// - tx pin resets tx, rx pin rx
// - float pin floats io; powerdown pin stops plls
// - pll reset digital only; ratio clock low
// - ratio plls multiply 2-8, divide 2-8
// - phase offset in 45 degree steps
// - duty cycle in eighths, 12.5-87.5
// - output delay in eighth-period steps
// - unity plls pass reference without counters
`timescale 1ns/1ps
`default_nettype none
`include "line_reset_regs.vh"
module line_interface_reset_pll_control (
  input  wire       core_clk_i,
  input  wire       srst_i,
  input  wire       ce_i,
  input  wire       fabric_config_i,
  input  wire       global_fabric_set_reset_n_i,
  input  wire       global_reset_inhibit_i,
  input  wire       fabric_reset_i,
  input  wire       tx_reset_pin_i,
  input  wire       rx_reset_pin_i,
  input  wire       float_all_io_pin_i,
  input  wire       pll_powerdown_pin_i,
  input  wire [2:0] tx_mult_i,
  input  wire [2:0] tx_div_i,
  input  wire [2:0] rx_mult_i,
  input  wire [2:0] rx_div_i,
  input  wire [2:0] phase_sel_i,
  input  wire [2:0] duty_sel_i,
  input  wire [2:0] delay_sel_i,
  input  wire       settings_load_i,
  output wire       tx_mux_rst_o,
  output wire       tx_pll_rst_o,
  output wire       rx_demux_rst_o,
  output wire       rx_pll_rst_o,
  output wire       tx_pll_pd_o,
  output wire       rx_pll_pd_o,
  output reg        io_oe_o,
  output reg        pll_stable_o,
  output reg        ratio_osc_hold_low_o,
  output reg        unity_osc_free_run_o,
  output reg  [2:0] tx_mult_o,
  output reg  [2:0] tx_div_o,
  output reg  [2:0] rx_mult_o,
  output reg  [2:0] rx_div_o,
  output reg  [2:0] phase_sel_o,
  output reg  [2:0] duty_sel_o,
  output reg  [2:0] delay_sel_o,
  output reg        unity_counters_bypass_o
);
  // settle timer states
  localparam [1:0] ST_RESET  = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_RUN    = 2'h2;

  // factor field: 0 codes 8, 1 codes 1 (unused), 2..7 code themselves
  function valid_factor;
    input [2:0] f;
    begin
      valid_factor = (f == `MULT_MAX) || (f >= `MULT_MIN);
    end
  endfunction

  // a multiply and divide pair loads only when both codes are legal
  function pair_ok;
    input [2:0] mult;
    input [2:0] div;
    begin
      pair_ok = valid_factor(mult) && valid_factor(div);
    end
  endfunction

  // pin synchronisers, two flops before any logic
  reg [3:0] pin_s1;
  reg [3:0] pin_s2;
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else if (ce_i) begin
      pin_s1 <= {pll_powerdown_pin_i, float_all_io_pin_i, rx_reset_pin_i, tx_reset_pin_i};
      pin_s2 <= pin_s1;
    end
  end
  wire tx_pin = pin_s2[0];
  wire rx_pin = pin_s2[1];
  wire fl_pin = pin_s2[2];
  wire pd_pin = pin_s2[3];

  // power-up counter holds all four block resets and floats io
  reg [3:0] por_cnt;
  wire      por_active = (por_cnt != `POR_CYC);
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      por_cnt <= 4'h0;
    end else if (ce_i && por_active) begin
      por_cnt <= por_cnt + 4'h1;
    end
  end

  // hold counter step: reload while the pin is high, then count down to zero
  function [`HOLD_W-1:0] hold_next;
    input               pin;
    input [`HOLD_W-1:0] cnt;
    begin
      if (pin) begin
        hold_next = `HOLD_LOAD;
      end else if (cnt != {`HOLD_W{1'b0}}) begin
        hold_next = cnt - {{(`HOLD_W-1){1'b0}}, 1'b1};
      end else begin
        hold_next = cnt;
      end
    end
  endfunction

  // minimum hold stretch for pin resets; the load covers 8 ns at this clock
  reg  [`HOLD_W-1:0] tx_hold_cnt;
  reg  [`HOLD_W-1:0] rx_hold_cnt;
  wire               tx_pin_hold = (tx_hold_cnt != {`HOLD_W{1'b0}});
  wire               rx_pin_hold = (rx_hold_cnt != {`HOLD_W{1'b0}});
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_hold_cnt <= `HOLD_LOAD;
      rx_hold_cnt <= `HOLD_LOAD;
    end else if (ce_i) begin
      tx_hold_cnt <= hold_next(tx_pin, tx_hold_cnt); // at least 8 ns of reset
      rx_hold_cnt <= hold_next(rx_pin, rx_hold_cnt);
    end
  end

  // combined fabric reset terms
  wire global_rst = ~global_fabric_set_reset_n_i & ~global_reset_inhibit_i;
  wire both_req   = por_active | fabric_config_i | global_rst | fabric_reset_i;
  wire tx_req     = both_req | tx_pin | tx_pin_hold;
  wire rx_req     = both_req | rx_pin | rx_pin_hold;

  // per-block release synchronisers
  reset_release_sync u_tx_mux (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .rst_req_i  (tx_req),
    .rst_o      (tx_mux_rst_o)
  );
  reset_release_sync u_tx_pll (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .rst_req_i  (tx_req),
    .rst_o      (tx_pll_rst_o)
  );
  reset_release_sync u_rx_demux (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .rst_req_i  (rx_req),
    .rst_o      (rx_demux_rst_o)
  );
  reset_release_sync u_rx_pll (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .rst_req_i  (rx_req),
    .rst_o      (rx_pll_rst_o)
  );

  // pll powerdown touches no reset
  assign tx_pll_pd_o = pd_pin;
  assign rx_pll_pd_o = pd_pin;

  // io drive: floated during power-up or by float pin only
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      io_oe_o <= 1'b0;
    end else if (ce_i) begin
      io_oe_o <= ~(por_active | fl_pin);
    end
  end

  // oscillator behaviour while a pll is held: digital reset only
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      ratio_osc_hold_low_o <= 1'b1;
      unity_osc_free_run_o <= 1'b1;
    end else if (ce_i) begin
      ratio_osc_hold_low_o <= tx_pll_rst_o | rx_pll_rst_o; // ratio output low
      unity_osc_free_run_o <= tx_pll_rst_o | rx_pll_rst_o; // unity runs slow, not stopped
    end
  end

  // settle timer: flags when pll clocks may be trusted
  reg [1:0]           st;
  reg [1:0]           next_st;
  reg [`SETTLE_W-1:0] settle_cnt;
  reg [`SETTLE_W-1:0] next_settle_cnt;
  reg                 next_pll_stable;
  wire                any_pll_hold = tx_pll_rst_o | rx_pll_rst_o | pd_pin;
  wire                settle_done  = (settle_cnt == `SETTLE_LAST);

  // next state of the settle timer; any pll hold restarts the wait
  always @* begin
    next_st         = st;
    next_settle_cnt = settle_cnt;
    next_pll_stable = pll_stable_o;
    case (st)
      ST_RESET: begin
        next_pll_stable = 1'b0;
        next_settle_cnt = {`SETTLE_W{1'b0}};
        if (!any_pll_hold) begin
          next_st = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (any_pll_hold) begin
          next_st = ST_RESET;
        end else if (settle_done) begin
          next_st         = ST_RUN; // 25 us before use
          next_pll_stable = 1'b1;
        end else begin
          next_settle_cnt = settle_cnt + {{(`SETTLE_W-1){1'b0}}, 1'b1};
        end
      end
      ST_RUN: begin
        if (any_pll_hold) begin
          next_st         = ST_RESET;
          next_pll_stable = 1'b0;
        end
      end
      default: begin
        next_st = ST_RESET;
      end
    endcase
  end

  // settle timer registers, frozen while the clock enable is low
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      st           <= ST_RESET;
      settle_cnt   <= {`SETTLE_W{1'b0}};
      pll_stable_o <= 1'b0;
    end else if (ce_i) begin
      st           <= next_st;
      settle_cnt   <= next_settle_cnt;
      pll_stable_o <= next_pll_stable;
    end
  end

  // next clock settings; an illegal pair or a zero duty keeps the old value
  reg [2:0] next_tx_mult;
  reg [2:0] next_tx_div;
  reg [2:0] next_rx_mult;
  reg [2:0] next_rx_div;
  reg [2:0] next_phase_sel;
  reg [2:0] next_duty_sel;
  reg [2:0] next_delay_sel;
  always @* begin
    next_tx_mult   = tx_mult_o;
    next_tx_div    = tx_div_o;
    next_rx_mult   = rx_mult_o;
    next_rx_div    = rx_div_o;
    next_phase_sel = phase_sel_o;
    next_duty_sel  = duty_sel_o;
    next_delay_sel = delay_sel_o;
    if (settings_load_i) begin
      if (pair_ok(tx_mult_i, tx_div_i)) begin
        next_tx_mult = tx_mult_i; // multiply and divide combine
        next_tx_div  = tx_div_i;
      end
      if (pair_ok(rx_mult_i, rx_div_i)) begin
        next_rx_mult = rx_mult_i;
        next_rx_div  = rx_div_i;
      end
      next_phase_sel = phase_sel_i; // 45 degrees per step
      if (duty_sel_i >= `DUTY_MIN) begin
        next_duty_sel = duty_sel_i; // eighths 1..7
      end
      next_delay_sel = delay_sel_i; // eighth-period delay
    end
  end

  // settings registers, frozen while the clock enable is low
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_mult_o   <= `MULT_MIN;
      tx_div_o    <= `DIV_MIN;
      rx_mult_o   <= `MULT_MIN;
      rx_div_o    <= `DIV_MIN;
      phase_sel_o <= `PHASE_DEFAULT;
      duty_sel_o  <= `DUTY_DEFAULT;
      delay_sel_o <= `DELAY_DEFAULT;
      unity_counters_bypass_o <= 1'b1;
    end else if (ce_i) begin
      tx_mult_o   <= next_tx_mult;
      tx_div_o    <= next_tx_div;
      rx_mult_o   <= next_rx_mult;
      rx_div_o    <= next_rx_div;
      phase_sel_o <= next_phase_sel;
      duty_sel_o  <= next_duty_sel;
      delay_sel_o <= next_delay_sel;
      unity_counters_bypass_o <= 1'b1; // unity plls skip counters
    end
  end
endmodule
`default_nettype wire

/* File: rtl/line_reset_regs.vh */
// constants for the line interface reset and clock control block
// assumes a 50 MHz core clock and inclusion by bare name
`ifndef LINE_RESET_REGS_VH
`define LINE_RESET_REGS_VH
`define CLK_PERIOD_NS        20
`define ASYNC_HOLD_NS        8
`define ASYNC_HOLD_CYC       ((`ASYNC_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_SETTLE_US        25
`define PLL_SETTLE_CYC       ((`PLL_SETTLE_US * 1000) / `CLK_PERIOD_NS)
`define SETTLE_W             11
`define POR_CYC              4'h8
`define MULT_MIN             3'h2
`define MULT_MAX             3'h0
`define DIV_MIN              3'h2
`define DIV_MAX              3'h0
`define EIGHTHS_W            3
`define DUTY_MIN             3'h1
`define DUTY_MAX             3'h7
`define DUTY_DEFAULT         3'h4
`define PHASE_DEFAULT        3'h0
`define DELAY_DEFAULT        3'h0
// pin reset stretch: counter width and load, one cycle covers ASYNC_HOLD_NS
`define HOLD_W               2
`define HOLD_LOAD            2'h1
// last settle count, PLL_SETTLE_CYC - 1 at the settle counter width
`define SETTLE_LAST          11'h4e1
`endif

/* File: rtl/reset_release_sync.v */
// two-stage release synchroniser for one sub-block reset
// assumes assertion arrives as a level on the core clock domain boundary
`timescale 1ns/1ps
`default_nettype none
module reset_release_sync (
  input  wire core_clk_i,
  input  wire srst_i,
  input  wire ce_i,
  input  wire rst_req_i,
  output wire rst_o
);
  reg stage1;
  reg stage2;
  // assert at once, release after two clean edges
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end else if (ce_i) begin
      stage1 <= rst_req_i;
      stage2 <= stage1;
    end
  end
  assign rst_o = stage2 | rst_req_i; // immediate assert, synced release
endmodule
`default_nettype wire

/* File: verif/fabric_partner.sv */
// fabric-side reset sequencer facing the reset control block
// assumes one clock shared with the block; go_i is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module fabric_partner (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic go_i,
  output logic      core_rst_o,
  output logic      fabric_hold_o
);
  logic [3:0] cnt;
  // step counter: 1..6 core resets high, fabric held until the count wraps
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt <= 4'h0;
    else if (go_i) cnt <= 4'h1;
    else if (cnt != 4'h0) cnt <= cnt + 4'h1;
  end
  // core released first, fabric afterwards; core held 6 cycles
  assign core_rst_o    = (cnt != 4'h0) && (cnt < 4'h7);
  assign fabric_hold_o = (cnt != 4'h0);
endmodule
`default_nettype wire

/* File: verif/line_interface_reset_pll_control_sva.sv */
// port assertions for the reset and clock control block
// assumes bind onto the block's top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module reset_ctl_sva (
  input wire logic       core_clk_i,
  input wire logic       srst_i,
  input wire logic       ce_i,
  input wire logic       fabric_config_i,
  input wire logic       fabric_reset_i,
  input wire logic       float_all_io_pin_i,
  input wire logic       pll_powerdown_pin_i,
  input wire logic       settings_load_i,
  input wire logic [2:0] duty_sel_i,
  input wire logic       tx_mux_rst_o,
  input wire logic       tx_pll_rst_o,
  input wire logic       rx_demux_rst_o,
  input wire logic       rx_pll_rst_o,
  input wire logic       tx_pll_pd_o,
  input wire logic       rx_pll_pd_o,
  input wire logic       io_oe_o,
  input wire logic       ratio_osc_hold_low_o,
  input wire logic [2:0] duty_sel_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  logic all_rst;
  // all four sub-blocks held
  assign all_rst = tx_mux_rst_o && tx_pll_rst_o && rx_demux_rst_o && rx_pll_rst_o;
  sequence s_held(x);
    (ce_i && x) [*4];
  endsequence
  sequence s_load;
    settings_load_i && ce_i;
  endsequence
  property p_srst; disable iff (1'b0) srst_i |=> all_rst && !io_oe_o; endproperty
  a_srst: assert property (p_srst) else $error("reset not applied");
  property p_frst; fabric_reset_i |-> all_rst; endproperty
  a_frst: assert property (p_frst) else $error("fabric reset ignored");
  property p_cfg; fabric_config_i |-> ##[0:2] all_rst; endproperty
  a_cfg: assert property (p_cfg) else $error("config reset missing");
  property p_flt; s_held(float_all_io_pin_i) |=> !io_oe_o; endproperty
  a_flt: assert property (p_flt) else $error("io not floated");
  property p_pd; s_held(pll_powerdown_pin_i) |=> tx_pll_pd_o && rx_pll_pd_o; endproperty
  a_pd: assert property (p_pd) else $error("pll not powered down");
  property p_hold; ce_i && (tx_pll_rst_o || rx_pll_rst_o) |=> ratio_osc_hold_low_o; endproperty
  a_hold: assert property (p_hold) else $error("ratio clock not held low");
  property p_duty; s_load ##0 duty_sel_i != 3'h0 |=> duty_sel_o == $past(duty_sel_i); endproperty
  a_duty: assert property (p_duty) else $error("duty not loaded");
  property p_duty0; s_load ##0 duty_sel_i == 3'h0 |=> $stable(duty_sel_o); endproperty
  a_duty0: assert property (p_duty0) else $error("zero duty taken");
endmodule
bind line_interface_reset_pll_control reset_ctl_sva u_sva (.core_clk_i, .srst_i, .ce_i, .fabric_config_i,
  .fabric_reset_i, .float_all_io_pin_i, .pll_powerdown_pin_i, .settings_load_i, .duty_sel_i, .tx_mux_rst_o,
  .tx_pll_rst_o, .rx_demux_rst_o, .rx_pll_rst_o, .tx_pll_pd_o, .rx_pll_pd_o, .io_oe_o, .ratio_osc_hold_low_o,
  .duty_sel_o);
`default_nettype wire

/* File: verif/tb_line_interface_reset_pll_control.sv */
// self-checking bench for the reset and clock control block
// assumes partner model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_line_interface_reset_pll_control;
  logic       clk, srst, ld, go, pc, ce, fh;
  logic [7:0] src;
  logic [2:0] m[4], em[4], mo[4], ph, du, dl, eph, edu, edl, pho, duo, dlo;
  logic [6:0] st;
  logic       stb, hl, byp, fr;
  int         err_count, cmp_count, i, n;
  line_interface_reset_pll_control dut (.core_clk_i(clk), .srst_i(srst), .ce_i(ce),
    .fabric_config_i(src[0]), .global_fabric_set_reset_n_i(!(src[1] | src[2])), .global_reset_inhibit_i(src[2]),
    .fabric_reset_i(src[3] | pc), .tx_reset_pin_i(src[5] | pc), .rx_reset_pin_i(src[6] | pc),
    .float_all_io_pin_i(src[4]), .pll_powerdown_pin_i(src[7]), .tx_mult_i(m[0]), .tx_div_i(m[1]),
    .rx_mult_i(m[2]), .rx_div_i(m[3]), .phase_sel_i(ph), .duty_sel_i(du), .delay_sel_i(dl), .settings_load_i(ld),
    .tx_mux_rst_o(st[6]), .tx_pll_rst_o(st[5]), .rx_demux_rst_o(st[4]), .rx_pll_rst_o(st[3]), .tx_pll_pd_o(st[2]),
    .rx_pll_pd_o(st[1]), .io_oe_o(st[0]), .pll_stable_o(stb), .ratio_osc_hold_low_o(hl), .unity_osc_free_run_o(fr),
    .tx_mult_o(mo[0]), .tx_div_o(mo[1]), .rx_mult_o(mo[2]), .rx_div_o(mo[3]), .phase_sel_o(pho),
    .duty_sel_o(duo), .delay_sel_o(dlo), .unity_counters_bypass_o(byp));
  fabric_partner u_fab (.clk_i(clk), .rst_i(srst), .go_i(go), .core_rst_o(pc), .fabric_hold_o(fh));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // status {txmux,txpll,rxdemux,rxpll,txpd,rxpd,oe} for one source
  function automatic logic [6:0] exp_src(input int s);
    case (s)
      2: return 7'b0000001;
      4: return 7'b0000000;
      5: return 7'b1100001;
      6: return 7'b0011001;
      7: return 7'b0000111;
      default: return 7'b1111001;
    endcase
  endfunction
  function automatic logic [2:0] pick(input logic [2:0] old, input logic [2:0] nw, input logic ok);
    return ok ? nw : old;
  endfunction
  initial begin
    srst = 1'b1; ce = 1'b1; ld = 1'b0; go = 1'b0; src = 8'h0; ph = 3'h0; du = 3'h4; dl = 3'h0;
    for (i = 0; i < 4; i++) begin
      m[i] = 3'h2; em[i] = 3'h2;
    end
    eph = 3'h0; edu = 3'h4; edl = 3'h0; err_count = 0; cmp_count = 0;
    void'($urandom(73804));
    step(3); srst = 1'b0; step(1);
    chk(st, 7'b1111000);
    for (n = 0; st[0] !== 1'b1 && n < 30; n++) step(1);
    step(4);
    chk(st, 7'b0000001);
    if (n == 30) begin
      err_count++;
      summarize();
    end
    $display("test powerup done");
    for (i = 0; i < 8; i++) begin
      src = 8'h1 << i; step(5);
      chk(st, exp_src(i));
      src = 8'h0; step(8);
      chk(st, 7'b0000001);
    end
    $display("test sources done");
    for (n = 0; n < 16; n++) begin
      for (i = 0; i < 4; i++) m[i] = (n == 0 && i == 0) ? 3'h1 : (n == 2) ? 3'h0 : 3'($urandom_range(7));
      ph = 3'($urandom); dl = 3'($urandom); du = (n == 1) ? 3'h0 : 3'($urandom); ld = 1'b1;
      for (i = 0; i < 4; i++) em[i] = pick(em[i], m[i], m[i & 2] != 3'h1 && m[i | 1] != 3'h1);
      eph = ph; edl = dl; edu = pick(edu, du, du != 3'h0);
      step(1);
      for (i = 0; i < 4; i++) chk({4'h0, mo[i]}, {4'h0, em[i]});
      chk({4'h0, pho}, {4'h0, eph});
      chk({4'h0, duo}, {4'h0, edu});
      chk({4'h0, dlo}, {4'h0, edl});
    end
    $display("test settings done");
    ce = 1'b0; src = 8'h10; du = (edu == 3'h7) ? 3'h1 : edu + 3'h1; step(5);
    chk(st, 7'b0000001);
    chk({4'h0, duo}, {4'h0, edu});
    ce = 1'b1; ld = 1'b0; step(5);
    chk(st, 7'b0000000);
    src = 8'h0; step(8);
    chk(st, 7'b0000001);
    $display("test enable done");
    go = 1'b1; step(1); go = 1'b0; step(2);
    chk(st, 7'b1111001);
    chk({5'h0, hl, fr}, 7'h3);
    for (n = 0; st[6] !== 1'b0 && n < 50; n++) step(1);
    if (n == 50) begin
      err_count++;
      summarize();
    end
    chk({6'h0, fh}, 7'h1);
    for (n = 0; stb !== 1'b1 && n < 1400; n++) step(1);
    chk({6'h0, n >= 1246 && n <= 1256}, 7'h1);
    chk({5'h0, hl, byp}, 7'h1);
    if (n == 1400) summarize();
    $display("test sequence done");
    summarize();
  end
endmodule
`default_nettype wire
